/* addressing_mode_decoder.sv */
// Addressing-mode decoder: mode, length and effective address for each instruction
// Functional notes
// RULE_01: Decode seventeen modes in seven groups
// RULE_02: Long modes reach whole 64K space
// RULE_03: Short modes confine address to page zero; short indexed forms here reach up to 1FEh
// RULE_04: Read-modify-write ops take short modes only
// RULE_05: Inherent instruction is exactly one byte
// RULE_06: Immediate: opcode then literal, two bytes
// RULE_07: No-offset index: X adds none, Y one
// RULE_08: Relative target from next-instruction counter
// RULE_09: Indexed address: index plus unsigned offset
// RULE_10: Relative adds signed eight-bit offset
// RULE_11: Three prefixes: alternate index or indirect
// RULE_12: Length is prefix, opcode plus operands
`timescale 1ns/10ps
module addressing_mode_decoder (
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        DEC_VALID_I,
	input  wire logic [7:0]  PREFIX_I,
	input  wire logic        PREFIX_VALID_I,
	input  wire logic [7:0]  OPCODE_I,
	input  wire amd_pkg::src_e SRC_I,
	input  wire logic        RMW_I,
	input  wire logic [15:0] OPERAND_I,
	input  wire logic [15:0] POINTER_I,
	input  wire logic [7:0]  INDEX_X_I,
	input  wire logic [7:0]  INDEX_Y_I,
	input  wire logic [15:0] PROGRAM_COUNTER_I,
	output logic             RESULT_VALID_O,
	output logic [4:0]       MODE_O,
	output logic [2:0]       GROUP_O,
	output logic [2:0]       LENGTH_O,
	output logic [1:0]       OPERAND_COUNT_O,
	output logic [15:0]      EFF_ADDR_O,
	output logic [15:0]      NEXT_PC_O,
	output logic [7:0]       IMMEDIATE_O,
	output logic             USES_ALT_INDEX_O,
	output logic             ILLEGAL_MODE_O
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] sext8(input logic [7:0] b);
		sext8 = b[amd_pkg::SIGN_BIT] ? (amd_pkg::BYTE_SIGN_EXT | {8'h00, b}) : {8'h00, b};
	endfunction

	function automatic logic [15:0] zext8(input logic [7:0] b);
		zext8 = {8'h00, b};
	endfunction

	// ****************************************
	// Prefix and mode resolution
	// ****************************************
	amd_pkg::mode_e  mode;
	amd_pkg::group_e group;
	logic [1:0]      op_count;
	logic            is_long;
	logic            alt_index;
	logic            pfx_ind;
	logic            pfx_alt;
	logic            pfx_altind;
	logic            illegal;

	always_comb begin
		pfx_alt    = PREFIX_VALID_I && (PREFIX_I == amd_pkg::PREFIX_ALT_INDEX);  // see RULE_11
		pfx_altind = PREFIX_VALID_I && (PREFIX_I == amd_pkg::PREFIX_ALT_INDIR);  // see RULE_11
		pfx_ind    = (PREFIX_VALID_I && (PREFIX_I == amd_pkg::PREFIX_INDIRECT)) || pfx_altind;
		alt_index  = pfx_alt || pfx_altind;
		illegal    = 1'b0;
		mode       = amd_pkg::AM_INHERENT;
		case (SRC_I) // see RULE_01
			amd_pkg::SRC_INHERENT:  mode = amd_pkg::AM_INHERENT;
			amd_pkg::SRC_IMMEDIATE: mode = amd_pkg::AM_IMMEDIATE;
			amd_pkg::SRC_DIR_SHORT: mode = pfx_ind ? amd_pkg::AM_IND_SHORT : amd_pkg::AM_DIR_SHORT;
			amd_pkg::SRC_DIR_LONG:  mode = amd_pkg::AM_DIR_LONG;
			amd_pkg::SRC_IND_LONGP: mode = pfx_ind ? amd_pkg::AM_IND_LONG : amd_pkg::AM_DIR_LONG;
			amd_pkg::SRC_IDX_NOOFS: mode = amd_pkg::AM_IDX_NOOFS;
			amd_pkg::SRC_IDX_SHORT: mode = pfx_ind ? amd_pkg::AM_INDIDX_SHORT : amd_pkg::AM_IDX_SHORT;
			amd_pkg::SRC_IDX_LONG:  mode = pfx_ind ? amd_pkg::AM_INDIDX_LONG : amd_pkg::AM_IDX_LONG;
			amd_pkg::SRC_REL:       mode = pfx_ind ? amd_pkg::AM_REL_IND : amd_pkg::AM_REL_DIR;
			amd_pkg::SRC_BIT:       mode = pfx_ind ? amd_pkg::AM_BIT_IND : amd_pkg::AM_BIT_DIR;
			amd_pkg::SRC_BITREL:    mode = pfx_ind ? amd_pkg::AM_BITREL_IND : amd_pkg::AM_BITREL_DIR;
			default: begin
				mode    = amd_pkg::AM_INHERENT;
				illegal = 1'b1;
			end
		endcase
		// Alternate-index-indirect prefix is legal only on indexed-indirect forms; any other mode is flagged illegal
		if (pfx_altind && !(mode == amd_pkg::AM_INDIDX_SHORT || mode == amd_pkg::AM_INDIDX_LONG)) begin
			illegal = 1'b1;
		end
	end

	amd_operand_len u_len (
		.mode_i      (mode),
		.alt_index_i (alt_index),
		.count_o     (op_count),
		.group_o     (group),
		.long_o      (is_long)
	);

	// ****************************************
	// Effective address
	// ****************************************
	logic [15:0] index_val;
	logic [15:0] next_pc;
	logic [15:0] ea;
	logic [2:0]  length;

	always_comb begin
		index_val = alt_index ? zext8(INDEX_Y_I) : zext8(INDEX_X_I);
		length    = amd_pkg::OPCODE_BYTES + {1'b0, op_count}; // see RULE_12
		if (PREFIX_VALID_I) begin
			length = length + amd_pkg::PREFIX_BYTES;
		end
		// Counter points at this instruction; its length is added before the target forms
		next_pc = PROGRAM_COUNTER_I + {13'h0000, length}; // see RULE_08
		ea      = 16'h0000;
		case (mode)
			amd_pkg::AM_DIR_SHORT, amd_pkg::AM_BIT_DIR, amd_pkg::AM_BITREL_DIR:
				ea = OPERAND_I & amd_pkg::PAGE_ZERO_MASK; // see RULE_03
			amd_pkg::AM_DIR_LONG:
				ea = OPERAND_I; // see RULE_02
			amd_pkg::AM_IDX_NOOFS:
				ea = index_val; // see RULE_09
			amd_pkg::AM_IDX_SHORT:
				ea = index_val + zext8(OPERAND_I[7:0]); // see RULE_09
			amd_pkg::AM_IDX_LONG:
				ea = index_val + OPERAND_I; // see RULE_09
			amd_pkg::AM_IND_SHORT, amd_pkg::AM_BIT_IND, amd_pkg::AM_BITREL_IND:
				ea = POINTER_I & amd_pkg::PAGE_ZERO_MASK; // see RULE_03
			amd_pkg::AM_IND_LONG:
				ea = POINTER_I; // see RULE_02
			amd_pkg::AM_INDIDX_SHORT:
				ea = index_val + zext8(POINTER_I[7:0]);
			amd_pkg::AM_INDIDX_LONG:
				ea = index_val + POINTER_I;
			amd_pkg::AM_REL_DIR:
				ea = next_pc + sext8(OPERAND_I[7:0]); // see RULE_10
			amd_pkg::AM_REL_IND:
				ea = next_pc + sext8(POINTER_I[7:0]); // see RULE_10
			default:
				ea = 16'h0000;
		endcase
	end

	// ****************************************
	// Result registers
	// ****************************************
	logic        valid_d, valid_q;
	logic [4:0]  mode_d, mode_q;
	logic [2:0]  group_d, group_q;
	logic [2:0]  len_d, len_q;
	logic [1:0]  cnt_d, cnt_q;
	logic [15:0] ea_d, ea_q;
	logic [15:0] npc_d, npc_q;
	logic [7:0]  imm_d, imm_q;
	logic        alt_d, alt_q;
	logic        ill_d, ill_q;

	always_comb begin
		valid_d = DEC_VALID_I;
		mode_d  = mode_q;
		group_d = group_q;
		len_d   = len_q;
		cnt_d   = cnt_q;
		ea_d    = ea_q;
		npc_d   = npc_q;
		imm_d   = imm_q;
		alt_d   = alt_q;
		ill_d   = ill_q;
		if (DEC_VALID_I) begin
			mode_d  = mode;
			group_d = group;
			len_d   = length;
			cnt_d   = op_count;
			ea_d    = ea;
			npc_d   = next_pc;
			// Literal is the byte right after the opcode
			imm_d   = (mode == amd_pkg::AM_IMMEDIATE) ? OPERAND_I[7:0] : 8'h00; // see RULE_06
			alt_d   = alt_index;
			// Memory read-modify-write has no long form; checked here to keep mode decode loop-free
			ill_d   = illegal || (RMW_I && is_long); // see RULE_04
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			valid_q <= 1'b0;
			mode_q  <= 5'h00;
			group_q <= 3'h0;
			len_q   <= 3'h0;
			cnt_q   <= 2'h0;
			ea_q    <= 16'h0000;
			npc_q   <= 16'h0000;
			imm_q   <= 8'h00;
			alt_q   <= 1'b0;
			ill_q   <= 1'b0;
		end else begin
			valid_q <= valid_d;
			mode_q  <= mode_d;
			group_q <= group_d;
			len_q   <= len_d;
			cnt_q   <= cnt_d;
			ea_q    <= ea_d;
			npc_q   <= npc_d;
			imm_q   <= imm_d;
			alt_q   <= alt_d;
			ill_q   <= ill_d;
		end
	end

	assign RESULT_VALID_O   = valid_q;
	assign MODE_O           = mode_q;
	assign GROUP_O          = group_q;
	assign LENGTH_O         = len_q;
	assign OPERAND_COUNT_O  = cnt_q;
	assign EFF_ADDR_O       = ea_q;
	assign NEXT_PC_O        = npc_q;
	assign IMMEDIATE_O      = imm_q;
	assign USES_ALT_INDEX_O = alt_q;
	assign ILLEGAL_MODE_O   = ill_q;

endmodule

/* amd_pkg.sv */
// Package: addressing-mode codes, prefix bytes, lengths and address limits
package amd_pkg;

	// ********************************
	// Addressing modes (17)
	// ********************************
	typedef enum logic [4:0] {
		AM_INHERENT      = 5'h00,
		AM_IMMEDIATE     = 5'h01,
		AM_DIR_SHORT     = 5'h02,
		AM_DIR_LONG      = 5'h03,
		AM_IDX_NOOFS     = 5'h04,
		AM_IDX_SHORT     = 5'h05,
		AM_IDX_LONG      = 5'h06,
		AM_IND_SHORT     = 5'h07,
		AM_IND_LONG      = 5'h08,
		AM_INDIDX_SHORT  = 5'h09,
		AM_INDIDX_LONG   = 5'h0A,
		AM_REL_DIR       = 5'h0B,
		AM_REL_IND       = 5'h0C,
		AM_BIT_DIR       = 5'h0D,
		AM_BIT_IND       = 5'h0E,
		AM_BITREL_DIR    = 5'h0F,
		AM_BITREL_IND    = 5'h10
	} mode_e;

	// ********************************
	// Main groups (7)
	// ********************************
	typedef enum logic [2:0] {
		GRP_INHERENT  = 3'h0,
		GRP_IMMEDIATE = 3'h1,
		GRP_DIRECT    = 3'h2,
		GRP_INDEXED   = 3'h3,
		GRP_INDIRECT  = 3'h4,
		GRP_RELATIVE  = 3'h5,
		GRP_BIT       = 3'h6
	} group_e;

	// Operand source as decoded from the opcode before prefix rewriting
	typedef enum logic [3:0] {
		SRC_INHERENT  = 4'h0,
		SRC_IMMEDIATE = 4'h1,
		SRC_DIR_SHORT = 4'h2,
		SRC_DIR_LONG  = 4'h3,
		SRC_IDX_NOOFS = 4'h4,
		SRC_IDX_SHORT = 4'h5,
		SRC_IDX_LONG  = 4'h6,
		SRC_REL       = 4'h7,
		SRC_BIT       = 4'h8,
		SRC_BITREL    = 4'h9,
		SRC_IND_LONGP = 4'hA
	} src_e;

	localparam logic [7:0] PREFIX_ALT_INDEX  = 8'h90;
	localparam logic [7:0] PREFIX_ALT_INDIR  = 8'h91;
	localparam logic [7:0] PREFIX_INDIRECT   = 8'h92;

	localparam logic [2:0] OPCODE_BYTES      = 3'h1;
	localparam logic [2:0] PREFIX_BYTES      = 3'h1;

	localparam logic [15:0] PAGE_ZERO_MASK   = 16'h00FF;
	localparam logic [15:0] BYTE_SIGN_EXT    = 16'hFF00;
	localparam int           SIGN_BIT        = 7;

endpackage

/* amd_operand_len.sv */
// Operand byte count per addressing mode
`timescale 1ns/10ps
module amd_operand_len (
	input  wire amd_pkg::mode_e mode_i,
	input  wire logic           alt_index_i,
	output logic [1:0]          count_o,
	output amd_pkg::group_e     group_o,
	output logic                long_o
);

	always_comb begin
		count_o = 2'h0;
		group_o = amd_pkg::GRP_INHERENT;
		long_o  = 1'b0;
		case (mode_i)
			amd_pkg::AM_INHERENT: begin
				count_o = 2'h0; // see RULE_05
				group_o = amd_pkg::GRP_INHERENT;
			end
			amd_pkg::AM_IMMEDIATE: begin
				count_o = 2'h1; // see RULE_06
				group_o = amd_pkg::GRP_IMMEDIATE;
			end
			amd_pkg::AM_DIR_SHORT: begin
				count_o = 2'h1;
				group_o = amd_pkg::GRP_DIRECT;
			end
			amd_pkg::AM_DIR_LONG: begin
				count_o = 2'h2; // see RULE_02
				group_o = amd_pkg::GRP_DIRECT;
				long_o  = 1'b1;
			end
			amd_pkg::AM_IDX_NOOFS: begin
				count_o = alt_index_i ? 2'h1 : 2'h0; // see RULE_07
				group_o = amd_pkg::GRP_INDEXED;
			end
			amd_pkg::AM_IDX_SHORT: begin
				count_o = 2'h1;
				group_o = amd_pkg::GRP_INDEXED;
			end
			amd_pkg::AM_IDX_LONG: begin
				count_o = 2'h2;
				group_o = amd_pkg::GRP_INDEXED;
				long_o  = 1'b1;
			end
			amd_pkg::AM_IND_SHORT, amd_pkg::AM_INDIDX_SHORT: begin
				count_o = 2'h2;
				group_o = amd_pkg::GRP_INDIRECT;
			end
			amd_pkg::AM_IND_LONG, amd_pkg::AM_INDIDX_LONG: begin
				count_o = 2'h2;
				group_o = amd_pkg::GRP_INDIRECT;
				long_o  = 1'b1;
			end
			amd_pkg::AM_REL_DIR: begin
				count_o = 2'h1;
				group_o = amd_pkg::GRP_RELATIVE;
			end
			amd_pkg::AM_REL_IND: begin
				count_o = 2'h2;
				group_o = amd_pkg::GRP_RELATIVE;
			end
			amd_pkg::AM_BIT_DIR: begin
				count_o = 2'h1;
				group_o = amd_pkg::GRP_BIT;
			end
			amd_pkg::AM_BIT_IND, amd_pkg::AM_BITREL_DIR: begin
				count_o = 2'h2;
				group_o = amd_pkg::GRP_BIT;
			end
			amd_pkg::AM_BITREL_IND: begin
				count_o = 2'h3;
				group_o = amd_pkg::GRP_BIT;
			end
			default: begin
				count_o = 2'h0;
				group_o = amd_pkg::GRP_INHERENT;
			end
		endcase
	end

endmodule

/* fetch_mem_model.sv */
// Memory model for the pointer reads behind the decoder
`timescale 1ns/10ps
module fetch_mem_model (
	input  wire logic [15:0] addr_i,
	output logic      [15:0] ptr_o
);
	// Word at a page-zero location; only the low address byte selects the word
	assign ptr_o = {~addr_i[7:0], addr_i[7:0] + 8'h11};
endmodule

/* amd_checker_assertions.sv */
// Checker: port-level properties of the addressing-mode decoder
`timescale 1ns/10ps
module amd_checker (
	input wire logic           REF_CLK_I,
	input wire logic           RST_I,
	input wire logic           DEC_VALID_I,
	input wire logic [7:0]     PREFIX_I,
	input wire logic           PREFIX_VALID_I,
	input wire amd_pkg::src_e  SRC_I,
	input wire logic           RMW_I,
	input wire logic [15:0]    OPERAND_I,
	input wire logic [7:0]     INDEX_X_I,
	input wire logic [15:0]    PROGRAM_COUNTER_I,
	input wire logic           RESULT_VALID_O,
	input wire logic [4:0]     MODE_O,
	input wire logic [2:0]     GROUP_O,
	input wire logic [2:0]     LENGTH_O,
	input wire logic [1:0]     OPERAND_COUNT_O,
	input wire logic [15:0]    EFF_ADDR_O,
	input wire logic [15:0]    NEXT_PC_O,
	input wire logic [7:0]     IMMEDIATE_O,
	input wire logic           USES_ALT_INDEX_O,
	input wire logic           ILLEGAL_MODE_O
);
	logic [15:0] pc_d, pc_q, off_d, off_q, ix_d, ix_q;
	logic        np;
	assign np = DEC_VALID_I && !PREFIX_VALID_I;
	always_comb begin
		pc_d  = PROGRAM_COUNTER_I;
		off_d = {{8{OPERAND_I[7]}}, OPERAND_I[7:0]};
		ix_d  = {8'h00, INDEX_X_I} + {8'h00, OPERAND_I[7:0]};
	end
	always_ff @(posedge REF_CLK_I) begin
		pc_q  <= pc_d;
		off_q <= off_d;
		ix_q  <= ix_d;
	end
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	a_answer_latency: assert property (DEC_VALID_I |=> RESULT_VALID_O)
		else $error("no answer after request");
	a_pulse_drop: assert property (!DEC_VALID_I |=> !RESULT_VALID_O)
		else $error("answer stood without request");
	a_next_pc_len: assert property (DEC_VALID_I |=> NEXT_PC_O == pc_q + {13'h0000, LENGTH_O})
		else $error("next counter not start plus length");
	a_inherent_len: assert property (np && SRC_I == amd_pkg::SRC_INHERENT |=> LENGTH_O == 3'h1 && OPERAND_COUNT_O == 2'h0)
		else $error("inherent length wrong");
	a_immediate_lit: assert property (np && SRC_I == amd_pkg::SRC_IMMEDIATE
		|=> LENGTH_O == 3'h2 && {8'h00, IMMEDIATE_O} == ($past(OPERAND_I) & 16'h00FF))
		else $error("immediate literal wrong");
	a_long_direct: assert property (np && SRC_I == amd_pkg::SRC_DIR_LONG |=> EFF_ADDR_O == $past(OPERAND_I))
		else $error("long address not full word");
	a_short_page: assert property (DEC_VALID_I && SRC_I == amd_pkg::SRC_DIR_SHORT |=> EFF_ADDR_O[15:8] == 8'h00)
		else $error("short address left page zero");
	a_rmw_long: assert property (np && RMW_I && SRC_I == amd_pkg::SRC_DIR_LONG |=> ILLEGAL_MODE_O)
		else $error("long mode on rmw not flagged");
	a_alt_noofs: assert property (DEC_VALID_I && PREFIX_VALID_I && PREFIX_I == amd_pkg::PREFIX_ALT_INDEX
		&& SRC_I == amd_pkg::SRC_IDX_NOOFS |=> USES_ALT_INDEX_O && OPERAND_COUNT_O == 2'h1)
		else $error("second index no-offset count wrong");
	a_index_sum: assert property (np && SRC_I == amd_pkg::SRC_IDX_SHORT |=> EFF_ADDR_O == ix_q)
		else $error("indexed sum wrong");
	a_rel_target: assert property (np && SRC_I == amd_pkg::SRC_REL |=> EFF_ADDR_O == pc_q + 16'h0002 + off_q)
		else $error("branch target wrong");
	a_mode_range: assert property (RESULT_VALID_O |-> MODE_O <= 5'h10 && GROUP_O <= 3'h6)
		else $error("mode or group code out of range");
	c_rel: cover property (np && SRC_I == amd_pkg::SRC_REL);
	c_alt: cover property (DEC_VALID_I && PREFIX_VALID_I);
	c_bad: cover property (ILLEGAL_MODE_O);
endmodule

/* addressing_mode_decoder_tb.sv */
// Testbench: directed scenarios for the addressing-mode decoder
`timescale 1ns/10ps
module addressing_mode_decoder_tb;
	logic          REF_CLK_I, RST_I, DEC_VALID_I, PREFIX_VALID_I, RMW_I;
	logic [7:0]    PREFIX_I, OPCODE_I, INDEX_X_I, INDEX_Y_I, IMMEDIATE_O;
	amd_pkg::src_e SRC_I;
	logic [15:0]   OPERAND_I, POINTER_I, PROGRAM_COUNTER_I, EFF_ADDR_O, NEXT_PC_O;
	logic          RESULT_VALID_O, USES_ALT_INDEX_O, ILLEGAL_MODE_O;
	logic [4:0]    MODE_O;
	logic [2:0]    GROUP_O, LENGTH_O;
	logic [1:0]    OPERAND_COUNT_O;
	int            bad_count, checks_done;
	addressing_mode_decoder DUT (
		.REF_CLK_I         (REF_CLK_I),
		.RST_I             (RST_I),
		.DEC_VALID_I       (DEC_VALID_I),
		.PREFIX_I          (PREFIX_I),
		.PREFIX_VALID_I    (PREFIX_VALID_I),
		.OPCODE_I          (OPCODE_I),
		.SRC_I             (SRC_I),
		.RMW_I             (RMW_I),
		.OPERAND_I         (OPERAND_I),
		.POINTER_I         (POINTER_I),
		.INDEX_X_I         (INDEX_X_I),
		.INDEX_Y_I         (INDEX_Y_I),
		.PROGRAM_COUNTER_I (PROGRAM_COUNTER_I),
		.RESULT_VALID_O    (RESULT_VALID_O),
		.MODE_O            (MODE_O),
		.GROUP_O           (GROUP_O),
		.LENGTH_O          (LENGTH_O),
		.OPERAND_COUNT_O   (OPERAND_COUNT_O),
		.EFF_ADDR_O        (EFF_ADDR_O),
		.NEXT_PC_O         (NEXT_PC_O),
		.IMMEDIATE_O       (IMMEDIATE_O),
		.USES_ALT_INDEX_O  (USES_ALT_INDEX_O),
		.ILLEGAL_MODE_O    (ILLEGAL_MODE_O)
	);
	fetch_mem_model partner (.addr_i(OPERAND_I), .ptr_o(POINTER_I));
	initial begin
		REF_CLK_I = 1'b0;
		forever #5 REF_CLK_I = ~REF_CLK_I;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ************************************
	// One request; answer read after its edge
	// ************************************
	task automatic issue(input logic [8:0] pre, input amd_pkg::src_e src, input logic rmw, input logic [15:0] opnd);
		@(posedge REF_CLK_I);
		PREFIX_VALID_I <= pre[8];
		PREFIX_I       <= pre[7:0];
		SRC_I          <= src;
		RMW_I          <= rmw;
		OPERAND_I      <= opnd;
		DEC_VALID_I    <= 1'b1;
		@(posedge REF_CLK_I);
		DEC_VALID_I <= 1'b0;
		#1;
		check(16'(RESULT_VALID_O), 16'h0001);
	endtask
	task automatic t_simple();
		issue(9'h000, amd_pkg::SRC_INHERENT, 1'b0, 16'hFFFF);
		check(16'(LENGTH_O), 16'h0001);
		check(NEXT_PC_O, 16'h0101);
		issue(9'h000, amd_pkg::SRC_IMMEDIATE, 1'b0, 16'h3C55);
		check(16'(IMMEDIATE_O), 16'h0055);
		check(16'(LENGTH_O), 16'h0002);
		$display("test simple done");
	endtask
	task automatic t_direct();
		issue(9'h000, amd_pkg::SRC_DIR_SHORT, 1'b0, 16'h12A5);
		check(EFF_ADDR_O, 16'h00A5);
		check(16'(GROUP_O), 16'(amd_pkg::GRP_DIRECT));
		issue(9'h000, amd_pkg::SRC_DIR_LONG, 1'b0, 16'hBEEF);
		check(EFF_ADDR_O, 16'hBEEF);
		check(16'(LENGTH_O), 16'h0003);
		$display("test direct done");
	endtask
	task automatic t_index();
		issue(9'h000, amd_pkg::SRC_IDX_SHORT, 1'b0, 16'h00FF);
		check(EFF_ADDR_O, 16'h01FE);
		issue(9'h000, amd_pkg::SRC_IDX_NOOFS, 1'b0, 16'h0000);
		check({EFF_ADDR_O[7:0], 6'h00, OPERAND_COUNT_O}, 16'hFF00);
		issue(9'h190, amd_pkg::SRC_IDX_NOOFS, 1'b0, 16'h0000);
		check(16'({USES_ALT_INDEX_O, LENGTH_O, OPERAND_COUNT_O}), 16'h002D);
		check(EFF_ADDR_O, 16'h0020);
		$display("test index done");
	endtask
	task automatic t_indirect();
		issue(9'h192, amd_pkg::SRC_DIR_SHORT, 1'b0, 16'h0010);
		check(16'(MODE_O), 16'(amd_pkg::AM_IND_SHORT));
		check(EFF_ADDR_O, 16'h0021);
		issue(9'h192, amd_pkg::SRC_IND_LONGP, 1'b0, 16'h0010);
		check(16'(MODE_O), 16'(amd_pkg::AM_IND_LONG));
		check(EFF_ADDR_O, 16'hEF21);
		$display("test indirect done");
	endtask
	task automatic t_relative();
		@(posedge REF_CLK_I);
		PROGRAM_COUNTER_I <= 16'h0200;
		issue(9'h000, amd_pkg::SRC_REL, 1'b0, 16'h0080);
		check(EFF_ADDR_O, 16'h0182);
		check(NEXT_PC_O, 16'h0202);
		issue(9'h000, amd_pkg::SRC_REL, 1'b0, 16'h007F);
		check(EFF_ADDR_O, 16'h0281);
		$display("test relative done");
	endtask
	task automatic t_rmw();
		issue(9'h000, amd_pkg::SRC_DIR_LONG, 1'b1, 16'h1234);
		check(16'(ILLEGAL_MODE_O), 16'h0001);
		issue(9'h000, amd_pkg::SRC_DIR_SHORT, 1'b1, 16'h0034);
		check(16'(ILLEGAL_MODE_O), 16'h0000);
		$display("test rmw done");
	endtask
	// ************************************
	// Modes the plain scenarios leave out; counter stays at 200h
	// ************************************
	task automatic t_modes();
		issue(9'h000, amd_pkg::SRC_IDX_LONG, 1'b0, 16'h1234);
		check(EFF_ADDR_O, 16'h1333);
		check(16'(LENGTH_O), 16'h0003);
		issue(9'h191, amd_pkg::SRC_IDX_SHORT, 1'b0, 16'h0010);
		check(EFF_ADDR_O, 16'h0041);
		check(16'({USES_ALT_INDEX_O, ILLEGAL_MODE_O}), 16'h0002);
		issue(9'h192, amd_pkg::SRC_IDX_LONG, 1'b0, 16'h0010);
		check(16'(MODE_O), 16'(amd_pkg::AM_INDIDX_LONG));
		check(EFF_ADDR_O, 16'hF020);
		issue(9'h191, amd_pkg::SRC_DIR_SHORT, 1'b0, 16'h0010);
		check(16'(ILLEGAL_MODE_O), 16'h0001);
		issue(9'h000, amd_pkg::src_e'(4'hF), 1'b0, 16'h0010);
		check(16'({MODE_O, ILLEGAL_MODE_O}), 16'h0001);
		issue(9'h000, amd_pkg::SRC_BIT, 1'b0, 16'h1255);
		check(EFF_ADDR_O, 16'h0055);
		check(16'(GROUP_O), 16'(amd_pkg::GRP_BIT));
		issue(9'h192, amd_pkg::SRC_BITREL, 1'b0, 16'h0010);
		check(16'({MODE_O, LENGTH_O}), 16'h0085);
		check(EFF_ADDR_O, 16'h0021);
		issue(9'h192, amd_pkg::SRC_REL, 1'b0, 16'h0010);
		check(EFF_ADDR_O, 16'h0225);
		check(NEXT_PC_O, 16'h0204);
		$display("test modes done");
	endtask
	task automatic t_reset();
		@(posedge REF_CLK_I);
		RST_I <= 1'b1;
		@(posedge REF_CLK_I);
		@(posedge REF_CLK_I);
		RST_I <= 1'b0;
		#1;
		check(EFF_ADDR_O | NEXT_PC_O, 16'h0000);
		check(16'({MODE_O, GROUP_O, LENGTH_O, OPERAND_COUNT_O}), 16'h0000);
		issue(9'h000, amd_pkg::SRC_INHERENT, 1'b0, 16'h0000);
		check(NEXT_PC_O, 16'h0201);
		$display("test reset done");
	endtask
	initial begin
		{RST_I, DEC_VALID_I, PREFIX_VALID_I, RMW_I} <= 4'h8;
		{PREFIX_I, OPCODE_I, INDEX_X_I, INDEX_Y_I} <= 32'h0000FF20;
		SRC_I <= amd_pkg::SRC_INHERENT;
		OPERAND_I <= 16'h0000;
		PROGRAM_COUNTER_I <= 16'h0100;
		bad_count = 0;
		checks_done = 0;
		repeat (8) @(posedge REF_CLK_I);
		RST_I <= 1'b0;
		t_simple();
		t_direct();
		t_index();
		t_indirect();
		t_relative();
		t_rmw();
		t_modes();
		t_reset();
		end_sim();
	end
	// Cuts a hang short
	initial begin
		repeat (2000) @(posedge REF_CLK_I);
		bad_count++;
		end_sim();
	end
endmodule
bind addressing_mode_decoder amd_checker chk (.REF_CLK_I, .RST_I, .DEC_VALID_I, .PREFIX_I, .PREFIX_VALID_I, .SRC_I,
	.RMW_I, .OPERAND_I, .INDEX_X_I, .PROGRAM_COUNTER_I, .RESULT_VALID_O, .MODE_O, .GROUP_O, .LENGTH_O,
	.OPERAND_COUNT_O, .EFF_ADDR_O, .NEXT_PC_O, .IMMEDIATE_O, .USES_ALT_INDEX_O, .ILLEGAL_MODE_O);
